// ---- core/rev_resp_pkg.sv ----
// package: constants, types and contract list for the reverse response framer
// Contract
// - all reverse transmissions go on lane 0; other lanes stay one-way.
// - reverse traffic is sent only in low-power signalling, never high-speed.
// - without header correction the correction byte is still sent as zero.
// - without payload checksum the long packet footer is all zeros.
// - every reverse transaction ends with a turnaround back to the host.
// - header correction byte uses the same calculation as the host.
// - checksum only in long packets; correction byte in short and long.
// - correction or checksum, if present, works in both directions.
// - error-free non-read with grant gets a plain acknowledge.
// - error-free read with grant returns the read data.
// - corrected single-bit read: data then error report with single-bit flag.
// - corrected single-bit non-read: execute, then report with single-bit flag.
// - multi-bit read error: report only with multi-bit flag, no data.
// - multi-bit non-read error: do not execute, report multi-bit flag.
// - start, sync, channel or command errors: report only, no access.
// - end sync, low-power sync or checksum errors: report with matching flags.
// - acknowledges are short packets; read replies short or long, forward format (the code always sends read replies long).
// - application events are signalled to the host as a trigger message.
// - one-way peripheral with correction still fixes single-bit header errors.
// - report order: identifier, error bits 0-7, bits 8-15, correction byte.
// - each error sets its own bit; bits 0,1,2,4,5 fixed as listed.
package rev_resp_pkg;
    localparam logic [5:0] DT_ACK = 6'h02;
    localparam logic [5:0] DT_ACK_ERR = 6'h02;
    localparam logic [5:0] DT_PLAIN_ACK = 6'h04;
    localparam logic [5:0] DT_RD_SHORT1 = 6'h11;
    localparam logic [5:0] DT_RD_LONG = 6'h1A;
    localparam logic [7:0] ZERO_ECC = 8'h00;
    localparam logic [15:0] ZERO_CSUM = 16'h0000;
    localparam logic [1:0] REPLY_LANE = 2'h0;
    localparam int BIT_SOT = 0;
    localparam int BIT_SOT_SYNC = 1;
    localparam int BIT_EOT_SYNC = 2;
    localparam int BIT_LP_SYNC = 4;
    localparam int BIT_RX_TMO = 5;
    localparam int BIT_RSVD = 6;
    localparam int BIT_ECC_SINGLE = 8;
    localparam int BIT_ECC_MULTI = 9;
    localparam int BIT_CSUM = 10;
    localparam int BIT_BAD_CMD = 11;
    localparam int BIT_BAD_VC = 12;
    localparam int MAX_RD_BYTES = 16;

    // errors seen on the forward transmission
    typedef struct packed {
        logic start_of_burst_error;
        logic start_of_burst_sync_error;
        logic end_of_burst_sync_error;
        logic low_power_tx_sync_error;
        logic rx_timeout;
        logic ecc_single;
        logic ecc_multi;
        logic csum_error;
        logic bad_command;
        logic virtual_channel_invalid;
    } fwd_err_t;

    // one received command from the forward path
    typedef struct packed {
        logic [1:0] vc;
        logic is_read;
        fwd_err_t err;
    } fwd_cmd_t;

    typedef enum logic [1:0] {
        SIG_STOP,
        SIG_LOW_POWER,
        SIG_HIGH_SPEED
    } sig_mode_t;
endpackage : rev_resp_pkg

// ---- core/rd_buf.sv ----
// file: small read data memory with registered read port
`timescale 1ns/1ps
module rd_buf #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [AW-1:0] raddr_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [DEPTH];
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        rdata_out <= mem[raddr_in];
    end
endmodule : rd_buf

// ---- core/rev_resp.sv ----
// file: reverse direction reply framer with turnaround handback
`timescale 1ns/1ps
module rev_resp #(
    parameter int RD_DEPTH = rev_resp_pkg::MAX_RD_BYTES
) (
    input wire logic clk_in,
    input wire logic srst_in,
    // command summary from the forward receiver, same clock
    input wire logic cmd_valid_in,
    input wire rev_resp_pkg::fwd_cmd_t cmd_in,
    input wire logic bus_turnaround_grant_in,
    // capability enables
    input wire logic ecc_en_in,
    input wire logic csum_en_in,
    input wire logic [7:0] ecc_in,
    input wire logic [15:0] csum_in,
    // read data source, loaded before the grant
    input wire logic rd_we_in,
    input wire logic [3:0] rd_addr_in,
    input wire logic [7:0] rd_data_in,
    input wire logic [4:0] rd_len_in,
    // application event from another domain
    input wire logic app_event_in,
    // outputs
    output logic exec_out,
    output logic byte_valid_out,
    output logic [7:0] byte_out,
    output logic [1:0] lane_out,
    output rev_resp_pkg::sig_mode_t sig_mode_out,
    output logic [7:0] ecc_src_out,
    output logic turnaround_out,
    output logic trigger_out,
    output logic [15:0] last_report_out
);
    // ************************************************
    // decode
    // ************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_RD_HDR,
        ST_RD_DATA,
        ST_RD_FOOT,
        ST_ACK,
        ST_TURN
    } state_t;

    state_t st_q;
    rev_resp_pkg::fwd_cmd_t cmd_q;
    logic [3:0] idx_q;
    logic [4:0] cnt_q;
    logic [15:0] rep_q;
    logic send_err_q;
    logic [1:0] ev_sync_q;
    logic ev_prev_q;
    logic [7:0] rd_byte;

    wire rev_resp_pkg::fwd_err_t e = cmd_in.err;
    wire hard_err = e.start_of_burst_error | e.start_of_burst_sync_error |
        e.virtual_channel_invalid | e.bad_command;
    wire blocked = hard_err | e.ecc_multi;
    wire [15:0] report;
    wire any_err = |report;
    wire send_data = cmd_q.is_read & ~(cmd_q.err.ecc_multi | cmd_q.err.start_of_burst_error |
        cmd_q.err.start_of_burst_sync_error | cmd_q.err.virtual_channel_invalid |
        cmd_q.err.bad_command);
    wire [7:0] hdr_ecc = ecc_en_in ? ecc_in : rev_resp_pkg::ZERO_ECC;
    wire [15:0] foot = csum_en_in ? csum_in : rev_resp_pkg::ZERO_CSUM;
    wire ev_rise = ev_sync_q[1] & ~ev_prev_q;
    // buffer read is registered: fetch one byte ahead while streaming
    wire [3:0] rd_raddr = (st_q == ST_RD_DATA) ? idx_q + 4'h1 : idx_q;

    // each error flag owns a fixed bit, bit 6 reserved
    generate
        for (genvar b = 0; b < 16; b++) begin : g_rep
            assign report[b] =
                (b == rev_resp_pkg::BIT_SOT) ? cmd_q.err.start_of_burst_error :
                (b == rev_resp_pkg::BIT_SOT_SYNC) ? cmd_q.err.start_of_burst_sync_error :
                (b == rev_resp_pkg::BIT_EOT_SYNC) ? cmd_q.err.end_of_burst_sync_error :
                (b == rev_resp_pkg::BIT_LP_SYNC) ? cmd_q.err.low_power_tx_sync_error :
                (b == rev_resp_pkg::BIT_RX_TMO) ? cmd_q.err.rx_timeout :
                (b == rev_resp_pkg::BIT_ECC_SINGLE) ? cmd_q.err.ecc_single :
                (b == rev_resp_pkg::BIT_ECC_MULTI) ? cmd_q.err.ecc_multi :
                (b == rev_resp_pkg::BIT_CSUM) ? cmd_q.err.csum_error :
                (b == rev_resp_pkg::BIT_BAD_CMD) ? cmd_q.err.bad_command :
                (b == rev_resp_pkg::BIT_BAD_VC) ? cmd_q.err.virtual_channel_invalid :
                1'b0;
        end
    endgenerate

    rd_buf #(.DEPTH(RD_DEPTH), .AW(4)) u_buf (
        .clk_in(clk_in),
        .we_in(rd_we_in),
        .waddr_in(rd_addr_in),
        .wdata_in(rd_data_in),
        .raddr_in(rd_raddr),
        .rdata_out(rd_byte)
    );

    // ************************************************
    // event trigger path
    // ************************************************
    // event crosses from the application domain: two flops before use
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ev_sync_q <= 2'h0;
            ev_prev_q <= 1'b0;
            trigger_out <= 1'b0;
        end else begin
            ev_sync_q <= {ev_sync_q[0], app_event_in};
            ev_prev_q <= ev_sync_q[1];
            trigger_out <= ev_rise;
        end
    end

    // ************************************************
    // reply sequencer
    // ************************************************
    // a read reply is always long so one framing path serves every length
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_q <= ST_IDLE;
            cmd_q <= '0;
            idx_q <= 4'h0;
            cnt_q <= 5'h00;
            rep_q <= 16'h0000;
            send_err_q <= 1'b0;
            exec_out <= 1'b0;
            byte_valid_out <= 1'b0;
            byte_out <= 8'h00;
            lane_out <= rev_resp_pkg::REPLY_LANE;
            sig_mode_out <= rev_resp_pkg::SIG_STOP;
            ecc_src_out <= 8'h00;
            turnaround_out <= 1'b0;
            last_report_out <= 16'h0000;
        end else begin
            exec_out <= 1'b0;
            byte_valid_out <= 1'b0;
            turnaround_out <= 1'b0;
            lane_out <= rev_resp_pkg::REPLY_LANE;
            case (st_q)
                ST_IDLE: begin
                    sig_mode_out <= rev_resp_pkg::SIG_STOP;
                    if (cmd_valid_in) begin
                        cmd_q <= cmd_in;
                        // single-bit errors are corrected upstream and still run
                        exec_out <= ~blocked & ~cmd_in.is_read;
                        st_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (bus_turnaround_grant_in) begin
                        sig_mode_out <= rev_resp_pkg::SIG_LOW_POWER;
                        rep_q <= report;
                        send_err_q <= any_err;
                        last_report_out <= report;
                        idx_q <= 4'h0;
                        cnt_q <= 5'h00;
                        st_q <= send_data ? ST_RD_HDR : ST_ACK;
                    end else if (cmd_valid_in) begin
                        // no grant: drop the reply silently
                        cmd_q <= cmd_in;
                        exec_out <= ~blocked & ~cmd_in.is_read;
                    end
                end
                ST_RD_HDR: begin
                    byte_valid_out <= 1'b1;
                    cnt_q <= cnt_q + 5'h01;
                    case (cnt_q)
                        5'h00: byte_out <= {cmd_q.vc, rev_resp_pkg::DT_RD_LONG};
                        5'h01: byte_out <= {3'h0, rd_len_in};
                        5'h02: byte_out <= 8'h00;
                        default: begin
                            byte_out <= hdr_ecc;
                            ecc_src_out <= {3'h0, rd_len_in};
                            cnt_q <= 5'h00;
                            st_q <= ST_RD_DATA;
                        end
                    endcase
                end
                ST_RD_DATA: begin
                    if (rd_len_in == 5'h00) begin
                        st_q <= ST_RD_FOOT;
                    end else begin
                        byte_valid_out <= 1'b1;
                        byte_out <= rd_byte;
                        idx_q <= idx_q + 4'h1;
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q + 5'h01 == rd_len_in) begin
                            cnt_q <= 5'h00;
                            st_q <= ST_RD_FOOT;
                        end
                    end
                end
                ST_RD_FOOT: begin
                    byte_valid_out <= 1'b1;
                    cnt_q <= cnt_q + 5'h01;
                    byte_out <= (cnt_q == 5'h00) ? foot[7:0] : foot[15:8];
                    if (cnt_q != 5'h00) begin
                        cnt_q <= 5'h00;
                        st_q <= send_err_q ? ST_ACK : ST_TURN;
                    end
                end
                ST_ACK: begin
                    byte_valid_out <= 1'b1;
                    cnt_q <= cnt_q + 5'h01;
                    if (!send_err_q) begin
                        // plain acknowledge: identifier then correction byte
                        byte_out <= (cnt_q == 5'h00) ?
                            {cmd_q.vc, rev_resp_pkg::DT_PLAIN_ACK} : hdr_ecc;
                        if (cnt_q != 5'h00) begin
                            st_q <= ST_TURN;
                        end
                    end else begin
                        case (cnt_q)
                            5'h00: byte_out <= {cmd_q.vc, rev_resp_pkg::DT_ACK_ERR};
                            5'h01: byte_out <= rep_q[7:0];
                            5'h02: byte_out <= rep_q[15:8];
                            default: begin
                                byte_out <= hdr_ecc;
                                st_q <= ST_TURN;
                            end
                        endcase
                    end
                end
                ST_TURN: begin
                    turnaround_out <= 1'b1;
                    sig_mode_out <= rev_resp_pkg::SIG_STOP;
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ************************************************
    // checks
    // ************************************************
    property p_lane0;
        @(posedge clk_in) disable iff (srst_in) byte_valid_out |-> lane_out == 2'h0;
    endproperty
    a_lane0: assert property (p_lane0) else $error("reply off lane 0");

    property p_lp_only;
        @(posedge clk_in) disable iff (srst_in)
            byte_valid_out |-> sig_mode_out == rev_resp_pkg::SIG_LOW_POWER;
    endproperty
    a_lp_only: assert property (p_lp_only) else $error("reply not low power");

    property p_turn_after;
        @(posedge clk_in) disable iff (srst_in)
            (st_q == ST_TURN) |=> turnaround_out && st_q == ST_IDLE;
    endproperty
    a_turn_after: assert property (p_turn_after) else $error("no turnaround");

    property p_no_grant_quiet;
        @(posedge clk_in) disable iff (srst_in)
            (st_q == ST_WAIT && !bus_turnaround_grant_in) |=> !byte_valid_out;
    endproperty
    a_no_grant_quiet: assert property (p_no_grant_quiet) else $error("reply no grant");

    property p_grant_reply;
        @(posedge clk_in) disable iff (srst_in)
            (st_q == ST_WAIT && bus_turnaround_grant_in) |=> ##[1:40] turnaround_out;
    endproperty
    a_grant_reply: assert property (p_grant_reply) else $error("grant unanswered");

    property p_multi_no_exec;
        @(posedge clk_in) disable iff (srst_in)
            (st_q == ST_IDLE && cmd_valid_in && cmd_in.err.ecc_multi) |=> !exec_out;
    endproperty
    a_multi_no_exec: assert property (p_multi_no_exec) else $error("multi executed");

    property p_hard_no_data;
        @(posedge clk_in) disable iff (srst_in)
            (st_q == ST_WAIT && bus_turnaround_grant_in && !send_data) |=> st_q == ST_ACK;
    endproperty
    a_hard_no_data: assert property (p_hard_no_data) else $error("data sent on error");

    property p_single_exec;
        @(posedge clk_in) disable iff (srst_in)
            (st_q == ST_IDLE && cmd_valid_in && !cmd_in.is_read && !blocked) |=> exec_out;
    endproperty
    a_single_exec: assert property (p_single_exec) else $error("command not run");

    property p_zero_ecc;
        @(posedge clk_in) disable iff (srst_in)
            (st_q == ST_ACK && !ecc_en_in &&
                (cnt_q == 5'h03 || (!send_err_q && cnt_q == 5'h01))) |=> byte_out == 8'h00;
    endproperty
    a_zero_ecc: assert property (p_zero_ecc) else $error("nonzero ecc");

    property p_rsvd;
        @(posedge clk_in) disable iff (srst_in) last_report_out[6] == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    c_read: cover property (@(posedge clk_in) st_q == ST_RD_FOOT ##1 st_q == ST_ACK);
    c_ack: cover property (@(posedge clk_in) st_q == ST_ACK ##1 st_q == ST_TURN);
    c_trig: cover property (@(posedge clk_in) trigger_out);
endmodule : rev_resp

// ---- verif/host_model.sv ----
// host side partner: sends command summaries and grants, collects the reply bytes
`timescale 1ns/1ps
module host_model (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic byte_valid_in,
    input wire logic [7:0] byte_in,
    input wire logic turnaround_in,
    output logic cmd_valid_out,
    output rev_resp_pkg::fwd_cmd_t cmd_out,
    output logic grant_out
);
    logic [7:0] rx_q[$];
    int ta_count = 0;
    int bytes_at_ta = 0;

    initial begin
        cmd_valid_out = 1'b0;
        cmd_out = '0;
        grant_out = 1'b0;
    end

    // ****************************************
    // reply capture
    // ****************************************
    always @(posedge clk_in) begin
        if (srst_in === 1'b0 && byte_valid_in === 1'b1) begin
            rx_q.push_back(byte_in);
        end
        // count of bytes at handback shows the bus came back only after the last byte
        if (srst_in === 1'b0 && turnaround_in === 1'b1) begin
            ta_count++;
            bytes_at_ta = rx_q.size();
        end
    end

    // one command, then a grant two edges later, or none at all
    task automatic send(input rev_resp_pkg::fwd_cmd_t c, input logic give);
        rx_q.delete();
        ta_count = 0;
        bytes_at_ta = 0;
        cmd_out <= c;
        cmd_valid_out <= 1'b1;
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        // summary no longer valid: scramble it so a late sample shows
        cmd_out <= ~c;
        @(posedge clk_in);
        grant_out <= give;
        @(posedge clk_in);
        grant_out <= 1'b0;
    endtask : send
endmodule : host_model

// ---- verif/rev_resp_test.sv ----
// self-checking bench for the reverse reply framer
`timescale 1ns/1ps
module rev_resp_test;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic cmd_valid;
    rev_resp_pkg::fwd_cmd_t cmd;
    logic grant;
    logic ecc_en = 1'b1;
    logic csum_en = 1'b1;
    logic [7:0] ecc_val = 8'hA5;
    logic [15:0] csum_val = 16'hBEEF;
    logic rd_we = 1'b0;
    logic [3:0] rd_addr = 4'h0;
    logic [7:0] rd_data = 8'h00;
    logic [4:0] rd_len = 5'h00;
    logic app_event = 1'b0;
    logic exec, byte_valid, turnaround, trigger;
    logic [7:0] byte_val;
    logic [7:0] ecc_src;
    logic [1:0] lane;
    logic [15:0] last_report;
    rev_resp_pkg::sig_mode_t sig_mode;
    rev_resp_pkg::fwd_err_t e;
    logic [7:0] exp_q[$];
    // error flag positions inside the packed summary, msb first
    int r18[4] = '{9, 8, 1, 0};
    int r19[4] = '{7, 6, 5, 2};
    int mismatches = 0;
    int n_compared = 0;
    int exec_count = 0;
    int trig_count = 0;

    always #10 clk_in = ~clk_in;

    rev_resp rev_resp_inst (.clk_in(clk_in), .srst_in(srst_in), .cmd_valid_in(cmd_valid),
        .cmd_in(cmd), .bus_turnaround_grant_in(grant), .ecc_en_in(ecc_en),
        .csum_en_in(csum_en), .ecc_in(ecc_val), .csum_in(csum_val), .rd_we_in(rd_we),
        .rd_addr_in(rd_addr), .rd_data_in(rd_data), .rd_len_in(rd_len),
        .app_event_in(app_event), .exec_out(exec), .byte_valid_out(byte_valid),
        .byte_out(byte_val), .lane_out(lane), .sig_mode_out(sig_mode), .ecc_src_out(ecc_src),
        .turnaround_out(turnaround), .trigger_out(trigger), .last_report_out(last_report));

    host_model host_model_inst (.clk_in(clk_in), .srst_in(srst_in), .byte_valid_in(byte_valid),
        .byte_in(byte_val), .turnaround_in(turnaround), .cmd_valid_out(cmd_valid),
        .cmd_out(cmd), .grant_out(grant));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    always @(posedge clk_in) begin
        if (exec === 1'b1) exec_count++;
        if (trigger === 1'b1) trig_count++;
        if (byte_valid === 1'b1) begin
            check("lane", rev_resp_pkg::REPLY_LANE, lane);
            check("mode", rev_resp_pkg::SIG_LOW_POWER, sig_mode);
        end
    end

    function automatic logic [15:0] rep(input rev_resp_pkg::fwd_err_t f);
        logic [15:0] r;
        r = '0;
        r[rev_resp_pkg::BIT_SOT] = f.start_of_burst_error;
        r[rev_resp_pkg::BIT_SOT_SYNC] = f.start_of_burst_sync_error;
        r[rev_resp_pkg::BIT_EOT_SYNC] = f.end_of_burst_sync_error;
        r[rev_resp_pkg::BIT_LP_SYNC] = f.low_power_tx_sync_error;
        r[rev_resp_pkg::BIT_RX_TMO] = f.rx_timeout;
        r[rev_resp_pkg::BIT_ECC_SINGLE] = f.ecc_single;
        r[rev_resp_pkg::BIT_ECC_MULTI] = f.ecc_multi;
        r[rev_resp_pkg::BIT_CSUM] = f.csum_error;
        r[rev_resp_pkg::BIT_BAD_CMD] = f.bad_command;
        r[rev_resp_pkg::BIT_BAD_VC] = f.virtual_channel_invalid;
        return r;
    endfunction : rep

    function automatic rev_resp_pkg::fwd_cmd_t mk(input logic [1:0] vc, input logic rd,
                                                  input rev_resp_pkg::fwd_err_t f);
        return '{vc: vc, is_read: rd, err: f};
    endfunction : mk

    // disabled correction must still show a zero byte, not the calculator value
    function automatic logic [7:0] ecc_x();
        return ecc_en ? ecc_val : 8'h00;
    endfunction : ecc_x

    function automatic void push_ack(input logic [1:0] vc);
        exp_q.push_back({vc, rev_resp_pkg::DT_PLAIN_ACK});
        exp_q.push_back(ecc_x());
    endfunction : push_ack

    function automatic void push_rep(input logic [1:0] vc, input rev_resp_pkg::fwd_err_t f);
        logic [15:0] r;
        r = rep(f);
        exp_q.push_back({vc, rev_resp_pkg::DT_ACK_ERR});
        exp_q.push_back(r[7:0]);
        exp_q.push_back(r[15:8]);
        exp_q.push_back(ecc_x());
    endfunction : push_rep

    function automatic void push_read(input logic [1:0] vc, input int n);
        logic [15:0] c;
        c = csum_en ? csum_val : 16'h0000;
        exp_q.push_back({vc, rev_resp_pkg::DT_RD_LONG});
        exp_q.push_back(8'(n));
        exp_q.push_back(8'h00);
        exp_q.push_back(ecc_x());
        for (int i = 0; i < n; i++) exp_q.push_back(8'h30 + 8'(i));
        exp_q.push_back(c[7:0]);
        exp_q.push_back(c[15:8]);
    endfunction : push_read

    task automatic load(input int n);
        for (int i = 0; i < n; i++) begin
            rd_we <= 1'b1;
            rd_addr <= 4'(i);
            rd_data <= 8'h30 + 8'(i);
            @(posedge clk_in);
        end
        rd_we <= 1'b0;
        rd_len <= 5'(n);
        @(posedge clk_in);
    endtask : load

    task automatic run(input string name, input rev_resp_pkg::fwd_cmd_t c, input logic g,
                       input int n_exec);
        exec_count = 0;
        host_model_inst.send(c, g);
        for (int i = 0; i < 60 && host_model_inst.ta_count == 0; i++) @(posedge clk_in);
        repeat (4) @(posedge clk_in);
        check({name, " handbacks"}, 32'(g), host_model_inst.ta_count);
        check({name, " bytes at handback"}, exp_q.size(), host_model_inst.bytes_at_ta);
        check({name, " byte count"}, exp_q.size(), host_model_inst.rx_q.size());
        foreach (exp_q[i]) begin
            if (i < host_model_inst.rx_q.size()) begin
                check($sformatf("%s byte %0d", name, i), exp_q[i], host_model_inst.rx_q[i]);
            end
        end
        if (n_exec >= 0) check({name, " exec"}, n_exec, exec_count);
        if (c.err != '0 && g) check({name, " report"}, rep(c.err), last_report);
        $display("test %s done", name);
        exp_q.delete();
    endtask : run

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // ****************************************
    // tests
    // ****************************************
    initial begin
        #100000;
        mismatches++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        push_ack(2'h1);
        run("plain ack", mk(2'h1, 1'b0, '0), 1'b1, 1);
        ecc_en <= 1'b0;
        ecc_val <= 8'h5A;
        @(posedge clk_in);
        push_ack(2'h1);
        run("ack zero ecc", mk(2'h1, 1'b0, '0), 1'b1, 1);
        run("no grant", mk(2'h0, 1'b0, '0), 1'b0, 1);
        ecc_en <= 1'b1;
        load(3);
        push_read(2'h3, 3);
        run("read", mk(2'h3, 1'b1, '0), 1'b1, -1);
        check("ecc source", 32'h3, ecc_src);
        csum_en <= 1'b0;
        load(16);
        e = rev_resp_pkg::fwd_err_t'(10'h010);
        push_read(2'h2, 16);
        push_rep(2'h2, e);
        run("read single", mk(2'h2, 1'b1, e), 1'b1, -1);
        push_rep(2'h1, e);
        run("write single", mk(2'h1, 1'b0, e), 1'b1, 1);
        e = rev_resp_pkg::fwd_err_t'(10'h008);
        push_rep(2'h2, e);
        run("read multi", mk(2'h2, 1'b1, e), 1'b1, 0);
        push_rep(2'h0, e);
        run("write multi", mk(2'h0, 1'b0, e), 1'b1, 0);
        foreach (r18[k]) begin
            e = rev_resp_pkg::fwd_err_t'(10'h001 << r18[k]);
            push_rep(2'h2, e);
            run("refused", mk(2'h2, 1'(k), e), 1'b1, 0);
        end
        foreach (r19[k]) begin
            e = rev_resp_pkg::fwd_err_t'(10'h001 << r19[k]);
            push_rep(2'h0, e);
            run("sync or sum", mk(2'h0, 1'b0, e), 1'b1, -1);
        end
        app_event <= 1'b1;
        repeat (10) @(posedge clk_in);
        app_event <= 1'b0;
        repeat (4) @(posedge clk_in);
        check("trigger pulses", 1, trig_count);
        $display("test trigger done");
        final_report();
    end
endmodule : rev_resp_test
